/* File: nvmcrb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module nvmcrb_top
  import nvmcrb_pkg::*;
#(
  parameter logic [15:0] EE_BASE = 16'h1400,
  parameter logic [15:0] EE_LAST = 16'h14FF,
  parameter logic [15:0] FLASH_BASE = 16'h8000,
  parameter logic [15:0] BOOT_LAST = 16'h81FF
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Register port, byte wide.
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_reg_from_debug,
  output logic [7:0] o_reg_rdata,
  // Key and instruction tracking.
  input wire logic i_key_write,
  input wire logic i_instr_done,
  input wire logic i_cpu_in_boot,
  // Stores into the page buffer.
  input wire logic i_store_valid,
  input wire logic [15:0] i_store_addr,
  // Boot section reads and fetches.
  input wire logic i_boot_hit,
  input wire logic [15:0] i_mem_rdata,
  output logic [15:0] o_mem_rdata,
  // Fuse and array sequencer.
  input wire logic i_eeprom_preserve_fuse,
  input wire logic i_op_done,
  output var nvmcrb_op_type o_op,
  output logic o_buf_clear,
  output logic o_cpu_halt,
  output logic o_app_wr_block,
  output logic o_boot_block,
  output logic o_irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    nvmcrb_state_type st;
    logic [2:0] cmd;
    logic boot_wr;
    logic boot_lock;
    logic app_wp;
    logic wr_fail;
    logic ee_busy;
    logic fl_busy;
    logic ready_en;
    logic ready_flag;
    logic [15:0] data;
    logic [15:0] addr;
    logic [2:0] key_cnt;
    logic [2:0] clr_cnt;
    logic buf_written;
    logic buf_mixed;
    logic buf_in_ee;
    logic in_boot;
    logic [7:0] rdata;
    logic [15:0] mem_rdata;
    nvmcrb_op_type op;
    logic buf_clear;
    logic halt;
    logic irq;
  } nvmcrb_regs_type;

  nvmcrb_regs_type r_q;
  nvmcrb_regs_type r_d;

  logic sel_ee;
  logic sel_app;
  logic sel_boot;
  logic st_ee;
  logic wr_cmd;
  logic cmd_ok;
  nvmcrb_cmd_type new_cmd;
  logic fail;

  // ****************************************
  // Address decode
  // ****************************************
  // Target memory follows the address register.
  // address picks memory
  assign sel_ee = (r_q.addr >= EE_BASE) && (r_q.addr <= EE_LAST);
  assign sel_boot = (r_q.addr >= FLASH_BASE) && (r_q.addr <= BOOT_LAST);
  assign sel_app = (r_q.addr > BOOT_LAST);
  assign st_ee = (i_store_addr >= EE_BASE) && (i_store_addr <= EE_LAST);
  assign new_cmd = nvmcrb_cmd_type'(i_reg_wdata[2:0]);
  assign wr_cmd = i_reg_wr && (i_reg_addr == OFS_COMMAND_CONTROL);

  // Command gate: key window for the processor, fuse program for the debug port only.
  always_comb begin
    cmd_ok = (r_q.st == ST_IDLE);
    if (!i_reg_from_debug && (r_q.key_cnt == 3'h0)) begin
      cmd_ok = 1'b0;
    end
    if (!i_reg_from_debug && (new_cmd == CMD_FUSE_PROGRAM)) begin
      cmd_ok = 1'b0;
    end
  end

  // Failure of the command being issued.
  always_comb begin
    fail = 1'b0;
    if ((new_cmd == CMD_PAGE_WRITE) || (new_cmd == CMD_PAGE_ERASE) ||
        (new_cmd == CMD_ERASE_WRITE)) begin
      fail = (sel_app && r_q.app_wp) || r_q.buf_mixed || (sel_boot && !i_cpu_in_boot);
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_d = r_q;
    r_d.op.start = 1'b0;
    r_d.buf_clear = 1'b0;
    r_d.rdata = RST_BYTE;
    r_d.in_boot = i_cpu_in_boot;

    // Key window counts down one per finished instruction.
    // four instruction window
    if (i_key_write) begin
      r_d.key_cnt = KEY_WINDOW_INSTR;
    end else if (i_instr_done && (r_q.key_cnt != 3'h0)) begin
      r_d.key_cnt = r_q.key_cnt - 3'h1;
    end

    // Page buffer stores track the last address and the written sections.
    // address on each store
    if (i_store_valid) begin
      r_d.addr = i_store_addr;
      r_d.buf_written = 1'b1;
      r_d.buf_in_ee = st_ee;
      if (r_q.buf_written && (r_q.buf_in_ee != st_ee)) begin
        r_d.buf_mixed = 1'b1;
      end
    end

    // Register writes. Unused bits are dropped.
    // unused bits ignored
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        OFS_PROTECTION_CONTROL: begin
          if (i_reg_wdata[BIT_APP_WRITE_PROTECT]) begin
            r_d.app_wp = 1'b1;
          end
          if (i_reg_wdata[BIT_BOOT_SECTION_LOCK] && i_cpu_in_boot) begin
            r_d.boot_wr = 1'b1;
          end
        end
        OFS_INTERRUPT_ENABLE: r_d.ready_en = i_reg_wdata[BIT_EEPROM_READY];
        OFS_INTERRUPT_FLAGS: begin
          if (i_reg_wdata[BIT_EEPROM_READY]) begin
            r_d.ready_flag = 1'b0;
          end
        end
        OFS_FUSE_DATA_LO: r_d.data[7:0] = i_reg_wdata;
        OFS_FUSE_DATA_HI: r_d.data[15:8] = i_reg_wdata;
        OFS_LAST_ADDRESS_LO: begin
          if (!i_store_valid) begin
            r_d.addr[7:0] = i_reg_wdata;
          end
        end
        OFS_LAST_ADDRESS_HI: begin
          if (!i_store_valid) begin
            r_d.addr[15:8] = i_reg_wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // Lock becomes active on the first exit from the boot section.
    // active on boot exit
    if (r_q.boot_wr && r_q.in_boot && !i_cpu_in_boot) begin
      r_d.boot_lock = 1'b1;
    end

    // Command controller.
    unique case (r_q.st)
      ST_IDLE: begin
        if (wr_cmd && cmd_ok) begin
          r_d.cmd = new_cmd;
          r_d.op.code = new_cmd;
          r_d.op.addr = r_q.addr;
          r_d.op.data = r_q.data;
          r_d.op.to_flash = 1'b0;
          r_d.op.to_eeprom = 1'b0;
          r_d.key_cnt = 3'h0;
          r_d.wr_fail = 1'b0;
          unique case (new_cmd)
            CMD_NONE: begin
            end
            CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_ERASE_WRITE: begin
              if (fail) begin
                r_d.wr_fail = 1'b1;
              end else if ((new_cmd == CMD_PAGE_WRITE) || r_q.buf_written) begin
                r_d.op.start = 1'b1;
                r_d.op.to_flash = !sel_ee;
                r_d.op.to_eeprom = sel_ee;
                r_d.ee_busy = sel_ee;
                r_d.fl_busy = !sel_ee;
                r_d.halt = !sel_ee;
                r_d.st = ST_RUN;
              end
            end
            CMD_BUFFER_CLEAR: begin
              r_d.buf_clear = 1'b1;
              r_d.halt = 1'b1;
              r_d.clr_cnt = BUF_CLEAR_CYCLES;
              r_d.st = ST_CLEAR;
            end
            CMD_FULL_ERASE: begin
              r_d.op.start = 1'b1;
              r_d.op.to_flash = 1'b1;
              r_d.op.to_eeprom = !i_eeprom_preserve_fuse;
              r_d.fl_busy = 1'b1;
              r_d.ee_busy = !i_eeprom_preserve_fuse;
              r_d.halt = 1'b1;
              r_d.st = ST_RUN;
            end
            CMD_EEPROM_WIPE: begin
              r_d.op.start = 1'b1;
              r_d.op.to_eeprom = 1'b1;
              r_d.ee_busy = 1'b1;
              r_d.halt = 1'b1;
              r_d.st = ST_RUN;
            end
            CMD_FUSE_PROGRAM: begin
              r_d.op.start = 1'b1;
              r_d.fl_busy = 1'b1;
              r_d.st = ST_RUN;
            end
          endcase
        end
      end
      ST_RUN: begin
        if (i_op_done) begin
          r_d.ee_busy = 1'b0;
          r_d.fl_busy = 1'b0;
          r_d.halt = 1'b0;
          r_d.st = ST_IDLE;
          if ((r_q.cmd == CMD_PAGE_WRITE) || (r_q.cmd == CMD_PAGE_ERASE) ||
              (r_q.cmd == CMD_ERASE_WRITE)) begin
            r_d.buf_clear = 1'b1;
            r_d.buf_written = 1'b0;
            r_d.buf_mixed = 1'b0;
          end
        end
      end
      ST_CLEAR: begin
        r_d.buf_written = 1'b0;
        r_d.buf_mixed = 1'b0;
        if (r_q.clr_cnt == 3'h1) begin
          r_d.halt = 1'b0;
          r_d.st = ST_IDLE;
        end else begin
          r_d.clr_cnt = r_q.clr_cnt - 3'h1;
        end
      end
      default: begin
        r_d.st = ST_IDLE;
        r_d.halt = 1'b0;
      end
    endcase

    // Ready flag is set whenever the EEPROM is idle; set wins over clear.
    // continuous request
    if (!r_d.ee_busy) begin
      r_d.ready_flag = 1'b1;
    end
    r_d.irq = r_d.ready_en & r_d.ready_flag;

    // Locked boot reads and fetches return zero.
    // block boot reads
    r_d.mem_rdata = (r_q.boot_lock && i_boot_hit) ? RST_WORD : i_mem_rdata;

    // Register read mux.
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        OFS_COMMAND_CONTROL: r_d.rdata = {5'h00, r_q.cmd};
        OFS_PROTECTION_CONTROL: r_d.rdata = {6'h00, r_q.boot_wr, r_q.app_wp};
        OFS_BUSY_ERROR_STATUS: r_d.rdata = {5'h00, r_q.wr_fail, r_q.ee_busy, r_q.fl_busy};
        OFS_INTERRUPT_ENABLE: r_d.rdata = {7'h00, r_q.ready_en};
        OFS_INTERRUPT_FLAGS: r_d.rdata = {7'h00, r_q.ready_flag};
        OFS_FUSE_DATA_LO: r_d.rdata = r_q.data[7:0];
        OFS_FUSE_DATA_HI: r_d.rdata = r_q.data[15:8];
        OFS_LAST_ADDRESS_LO: r_d.rdata = r_q.addr[7:0];
        OFS_LAST_ADDRESS_HI: r_d.rdata = r_q.addr[15:8];
        default: r_d.rdata = RST_BYTE;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs come straight from the state register.
  assign o_reg_rdata = r_q.rdata;
  assign o_mem_rdata = r_q.mem_rdata;
  assign o_op = r_q.op;
  assign o_buf_clear = r_q.buf_clear;
  assign o_cpu_halt = r_q.halt;
  assign o_app_wr_block = r_q.app_wp;
  assign o_boot_block = r_q.boot_lock;
  // Interrupt level is registered with the enable and flag it follows.
  assign o_irq = r_q.irq;

endmodule
`default_nettype wire

/* File: nvmcrb_pkg.sv */
package nvmcrb_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFS_COMMAND_CONTROL = 4'h0;
  localparam logic [3:0] OFS_PROTECTION_CONTROL = 4'h1;
  localparam logic [3:0] OFS_BUSY_ERROR_STATUS = 4'h2;
  localparam logic [3:0] OFS_INTERRUPT_ENABLE = 4'h3;
  localparam logic [3:0] OFS_INTERRUPT_FLAGS = 4'h4;
  localparam logic [3:0] OFS_FUSE_DATA_LO = 4'h6;
  localparam logic [3:0] OFS_FUSE_DATA_HI = 4'h7;
  localparam logic [3:0] OFS_LAST_ADDRESS_LO = 4'h8;
  localparam logic [3:0] OFS_LAST_ADDRESS_HI = 4'h9;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BIT_APP_WRITE_PROTECT = 0;
  localparam int BIT_BOOT_SECTION_LOCK = 1;
  localparam int BIT_FLASH_BUSY = 0;
  localparam int BIT_EEPROM_BUSY = 1;
  localparam int BIT_WRITE_FAIL = 2;
  localparam int BIT_EEPROM_READY = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [2:0] KEY_WINDOW_INSTR = 3'h4;
  localparam logic [2:0] BUF_CLEAR_CYCLES = 3'h7;

  // Command codes.
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_PAGE_WRITE = 3'h1,
    CMD_PAGE_ERASE = 3'h2,
    CMD_ERASE_WRITE = 3'h3,
    CMD_BUFFER_CLEAR = 3'h4,
    CMD_FULL_ERASE = 3'h5,
    CMD_EEPROM_WIPE = 3'h6,
    CMD_FUSE_PROGRAM = 3'h7
  } nvmcrb_cmd_type;

  // Controller states, Gray coded along idle, run, clear.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_CLEAR = 2'b11
  } nvmcrb_state_type;

  // Operation request sent to the array sequencer.
  typedef struct packed {
    logic start;
    nvmcrb_cmd_type code;
    logic to_flash;
    logic to_eeprom;
    logic [15:0] addr;
    logic [15:0] data;
  } nvmcrb_op_type;

endpackage

/* File: nvmcrb_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module nvmcrb_assertions
  import nvmcrb_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Register writes and tracking.
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_from_debug,
  input wire logic i_key_write,
  input wire logic i_instr_done,
  input wire logic i_cpu_in_boot,
  input wire logic i_boot_hit,
  // Design outputs.
  input wire logic [15:0] o_mem_rdata,
  input wire nvmcrb_op_type o_op,
  input wire logic o_buf_clear,
  input wire logic o_cpu_halt,
  input wire logic o_app_wr_block,
  input wire logic o_boot_block,
  input wire logic o_irq
);
  logic [2:0] key_cnt_q;

  // Instructions left before the key lapses.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_key_write) begin
      key_cnt_q <= i_srst ? 3'h0 : KEY_WINDOW_INSTR;
    end else if (i_instr_done && (key_cnt_q != 3'h0)) begin
      key_cnt_q <= key_cnt_q - 3'h1;
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // A processor write to the command field, then three launch-free cycles.
  sequence cpu_cmd_s;
    i_reg_wr && (i_reg_addr == OFS_COMMAND_CONTROL) && !i_reg_from_debug;
  endsequence
  sequence quiet_s;
    (!o_op.start && !o_buf_clear) [*3];
  endsequence

  no_key_ignored_a: assert property (cpu_cmd_s ##0 (key_cnt_q == 3'h0) |=> quiet_s)
    else $error("command taken without key");
  fuse_cpu_refused_a: assert property (cpu_cmd_s ##0 (i_reg_wdata[2:0] == 3'h7) |=> quiet_s)
    else $error("fuse command taken from processor");
  clear_halt_a: assert property (o_buf_clear && o_cpu_halt |-> o_cpu_halt [*7] ##1 !o_cpu_halt)
    else $error("buffer clear stall not seven cycles");
  boot_read_zero_a: assert property (o_boot_block && i_boot_hit |=> o_mem_rdata == 16'h0000)
    else $error("locked boot read not zero");
  boot_wait_a: assert property (!o_boot_block && i_cpu_in_boot |=> !o_boot_block)
    else $error("boot lock active inside boot");
  boot_sticky_a: assert property (o_boot_block |=> o_boot_block)
    else $error("boot lock cleared without reset");
  app_sticky_a: assert property (o_app_wr_block |=> o_app_wr_block)
    else $error("write protect cleared without reset");
  irq_off_a: assert property (i_reg_wr && (i_reg_addr == OFS_INTERRUPT_ENABLE)
    && !i_reg_wdata[0] |=> !o_irq)
    else $error("interrupt stays after disable");
endmodule

bind nvmcrb_top nvmcrb_assertions i_chk (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_from_debug(i_reg_from_debug),
  .i_key_write(i_key_write), .i_instr_done(i_instr_done), .i_cpu_in_boot(i_cpu_in_boot),
  .i_boot_hit(i_boot_hit), .o_mem_rdata(o_mem_rdata), .o_op(o_op),
  .o_buf_clear(o_buf_clear), .o_cpu_halt(o_cpu_halt), .o_app_wr_block(o_app_wr_block),
  .o_boot_block(o_boot_block), .o_irq(o_irq)
);
`default_nettype wire

/* File: nvmcrb_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nvmcrb_seq_model #(
  parameter int LAT = 5
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Operation handshake.
  input wire logic i_start,
  output logic o_done
);
  int cnt_q;

  // Counts out the array time, then pulses done for one cycle.
  always @(posedge i_core_clk) begin
    o_done <= !i_srst && (cnt_q == 1);
    cnt_q <= i_srst ? 0 : i_start ? LAT : (cnt_q > 0) ? cnt_q - 1 : 0;
  end
endmodule
`default_nettype wire

/* File: test_nvm_command_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module test_nvm_command_register_bank
  import nvmcrb_pkg::*;
();
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, dbg = 1'b0, key = 1'b0;
  logic idone = 1'b0, boot = 1'b0, hit = 1'b0, st = 1'b0, keep = 1'b0, done, seen;
  logic buf_clr, halt, app_blk, boot_blk, irq, clr_seen, halt_seen;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, got;
  logic [15:0] saddr = 16'h0000, mem_in = 16'hABCD, mem_out;
  nvmcrb_op_type op, cap;
  int failures = 0, check_count = 0;

  // Free-running core clock.
  always #5 clk = ~clk;

  nvmcrb_top i_dut (
    .i_core_clk(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_from_debug(dbg), .o_reg_rdata(rdata), .i_key_write(key),
    .i_instr_done(idone), .i_cpu_in_boot(boot), .i_store_valid(st), .i_store_addr(saddr),
    .i_boot_hit(hit), .i_mem_rdata(mem_in), .o_mem_rdata(mem_out),
    .i_eeprom_preserve_fuse(keep), .i_op_done(done), .o_op(op), .o_buf_clear(buf_clr),
    .o_cpu_halt(halt), .o_app_wr_block(app_blk), .o_boot_block(boot_blk), .o_irq(irq)
  );
  nvmcrb_seq_model i_seq (.i_core_clk(clk), .i_srst(srst), .i_start(op.start), .o_done(done));

  // Steps n edges, then moves 1 ns past the last one.
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bchk(input string n, input logic e, input logic g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask

  // One register access; answers are captured in the cycle after the taking edge.
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = w;
    rd = ~w;
    tk(1);
    wr = 1'b0;
    rd = 1'b0;
    got = rdata;
    cap = op;
    clr_seen = buf_clr;
    halt_seen = halt;
    tk(1);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("register", {8'h00, e}, {8'h00, got});
  endtask

  // Optional key pulse, then the command write on the next edge.
  task automatic cmd(input logic [2:0] c, input logic k, input logic d);
    dbg = d;
    key = k;
    tk(1);
    key = 1'b0;
    acc(1'b1, 4'h0, {5'h00, c});
  endtask

  task automatic store(input logic [15:0] a);
    saddr = a;
    st = 1'b1;
    tk(1);
    st = 1'b0;
    tk(1);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #100000;
    failures++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    tk(20);
    srst = 1'b0;
    for (int a = 0; a < 10; a++) begin
      if (a != 4) rchk(4'(a), 8'h00);
    end
    acc(1'b1, 4'h6, 8'h34);
    acc(1'b1, 4'h7, 8'h12);
    acc(1'b1, 4'h9, 8'h82);
    rchk(4'h7, 8'h12);
    acc(1'b1, 4'h3, 8'hFF);
    rchk(4'h3, 8'h01);
    bchk("irq", 1'b1, irq);
    acc(1'b1, 4'h4, 8'h01);
    bchk("irq", 1'b1, irq);
    acc(1'b1, 4'h3, 8'h00);
    bchk("irq", 1'b0, irq);
    cmd(3'h4, 1'b0, 1'b0);
    bchk("clear", 1'b0, clr_seen);
    cmd(3'h4, 1'b1, 1'b0);
    bchk("clear", 1'b1, clr_seen);
    bchk("halt", 1'b1, halt_seen);
    tk(8);
    // Key, then four retired instructions before the command.
    key = 1'b1;
    tk(1);
    key = 1'b0;
    idone = 1'b1;
    tk(4);
    idone = 1'b0;
    acc(1'b1, 4'h0, 8'h04);
    bchk("clear", 1'b0, clr_seen);
    cmd(3'h7, 1'b1, 1'b0);
    bchk("start", 1'b0, cap.start);
    cmd(3'h7, 1'b0, 1'b1);
    bchk("start", 1'b1, cap.start);
    chk("data", 16'h1234, cap.data);
    tk(10);
    store(16'h1410);
    rchk(4'h8, 8'h10);
    cmd(3'h3, 1'b1, 1'b0);
    bchk("eeprom", 1'b1, cap.to_eeprom);
    rchk(4'h2, 8'h02);
    // While the EEPROM is busy the flag is not set again, so a write of one clears it.
    acc(1'b1, 4'h4, 8'h01);
    rchk(4'h4, 8'h00);
    tk(10);
    store(16'h8200);
    cmd(3'h1, 1'b1, 1'b0);
    bchk("flash", 1'b1, cap.to_flash);
    rchk(4'h2, 8'h01);
    seen = 1'b0;
    repeat (12) begin
      seen = seen | buf_clr;
      tk(1);
    end
    bchk("auto clear", 1'b1, seen);
    cmd(3'h2, 1'b1, 1'b0);
    bchk("start", 1'b0, cap.start);
    for (int k = 0; k < 2; k++) begin
      keep = k[0];
      cmd(3'h5, 1'b1, 1'b0);
      bchk("eeprom", ~keep, cap.to_eeprom);
      tk(10);
    end
    acc(1'b1, 4'h1, 8'h01);
    acc(1'b1, 4'h1, 8'h02);
    rchk(4'h1, 8'h01);
    bchk("protect", 1'b1, app_blk);
    store(16'h8200);
    cmd(3'h1, 1'b1, 1'b0);
    bchk("start", 1'b0, cap.start);
    rchk(4'h2, 8'h04);
    cmd(3'h4, 1'b1, 1'b0);
    tk(8);
    rchk(4'h2, 8'h00);
    hit = 1'b1;
    boot = 1'b1;
    acc(1'b1, 4'h1, 8'h02);
    bchk("boot", 1'b0, boot_blk);
    chk("fetch", 16'hABCD, mem_out);
    boot = 1'b0;
    tk(3);
    bchk("boot", 1'b1, boot_blk);
    chk("fetch", 16'h0000, mem_out);
    // A reset in mid-run is the only way back for both protection bits.
    srst = 1'b1;
    tk(2);
    srst = 1'b0;
    tk(1);
    bchk("boot", 1'b0, boot_blk);
    bchk("protect", 1'b0, app_blk);
    chk("fetch", 16'hABCD, mem_out);
    wrap_up();
  end
endmodule
`default_nettype wire
